// *** host_probe.sv ***
/*
  Host debugger model: drives the test clock, mode-select and test data in.
  Assumes the bench calls bit_cycle; the clock stands low between calls.
*/
`timescale 1ns/1ps
`default_nettype none
module host_probe (
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo
);
  // Idle levels: clock still, mode-select high so the TAP stays parked.
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // One 6 ns bit; data out is taken just before the rising edge. Mode-select
  // and data change only here, just after the falling edge. The bench runs
  // faster than a real host may; the logic only needs the clocks unrelated.
  task automatic bit_cycle(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #3;
    tdo = i_tdo;
    o_tck = 1'b1;
    #3;
    o_tck = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** jtag_dap_params.svh ***
/*
  Constants for the debug access port: instruction codes, debug port select
  encodings, trace modes and the key window timing.
  Assumes it is included by its bare name from the design files.
*/
`ifndef JTAG_DAP_PARAMS_SVH
`define JTAG_DAP_PARAMS_SVH

// Instruction register layout and codes.
`define IR_WIDTH 4
`define IR_CAPTURE 4'h1
`define IR_EXTEST 4'h0
`define IR_SAMPLE 4'h1
`define IR_RESET_REQ 4'h8
`define IR_DBG_STATUS 4'h9
`define IR_IDCODE 4'he
`define IR_BYPASS 4'hf

// Data register lengths in bits.
`define IDCODE_LEN 32
`define ONE_BIT_LEN 1

// Debug port select setting encodings.
`define DPS_JTAG4 2'h0
`define DPS_JTAG5 2'h1
`define DPS_SWD 2'h2
`define DPS_DISABLED 2'h3

// Trace output mode select.
`define TRACE_MODE_SERIAL 1'h0
`define TRACE_MODE_PARALLEL 1'h1

// Key window after reset, in its own unit, and the core clock period.
`define KEY_WINDOW_NS 8000
`define CORE_CLK_PERIOD_NS 40
`define KEY_WINDOW_CYC (`KEY_WINDOW_NS / `CORE_CLK_PERIOD_NS)
`define KEY_CNT_W 9

`endif

// *** jtag_dap_pkg.sv ***
/*
  Types shared by the debug access port: TAP controller states and the
  bundle of control levels that crosses into the test clock domain.
  Assumes nothing of its surroundings.
*/
package jtag_dap_pkg;

  typedef enum logic [3:0] {
    st_reset, st_idle,
    st_sel_dr, st_cap_dr, st_shift_dr, st_exit1_dr, st_pause_dr, st_exit2_dr, st_upd_dr,
    st_sel_ir, st_cap_ir, st_shift_ir, st_exit1_ir, st_pause_ir, st_exit2_ir, st_upd_ir
  } tap_state_e;

  typedef logic [1:0] dps_t;

  // Levels the test clock logic needs; each is a flop output or a pin.
  typedef struct packed {
    logic ext_rst_n;
    logic trst_pin_n;
    logic jtag_en;
    logic trst_en;
    logic dbg_active;
  } link_cfg_s;

endpackage

// *** jtag_dap_sync.sv ***
/*
  Two flip-flop synchroniser for a bundle of independent levels.
  Assumes each bit is a level that may change at any time; bits are not
  guaranteed to arrive in the same cycle as each other.
*/
`timescale 1ns/1ps
`default_nettype none

module jtag_dap_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk) begin
    stage1_reg <= i_d;
    stage2_reg <= stage1_reg;
  end

  assign o_q = stage2_reg;

endmodule

`default_nettype wire

// *** jtag_debug_access_port.sv ***
/*
  Debug and programming access port: a boundary-scan TAP on the test clock,
  and on the core clock the debug port select and lockout capture, the
  two-wire key window, the debug module enable and the trace outputs.
  Assumes the test clock and the core clock are unrelated, that the two-wire
  protocol engine sits outside on the core clock, and that the straps
  change only while reset is held.
*/
`timescale 1ns/1ps
`default_nettype none
`include "jtag_dap_params.svh"

module jtag_debug_access_port #(
  parameter int BSR_LEN = 8,
  parameter int TRACE_W = 4,
  parameter logic [31:0] IDCODE_VALUE = 32'h0a5a_5001 // Arbitrary value.
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_test_clk,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_test_reset_n,
  output logic o_tdo,
  output logic o_tdo_oe,
  output logic o_tms_out,
  output logic o_tms_oe,
  input wire logic [1:0] i_debug_port_select_setting,
  input wire logic i_nonvolatile_config_latch_lock,
  input wire logic i_swd_key_seen,
  input wire logic i_swd_switch_to_jtag,
  input wire logic i_swd_data,
  input wire logic i_swd_drive,
  input wire logic i_fw_debug_enable,
  output logic o_jtag_pins_enabled,
  output logic o_swd_acquired,
  output logic o_debug_modules_active,
  output logic o_device_reset_req,
  input wire logic [BSR_LEN-1:0] i_pin_sample,
  output logic [BSR_LEN-1:0] o_pin_drive,
  output logic o_pin_extest,
  input wire logic i_trace_mode,
  input wire logic i_trace_valid,
  input wire logic [TRACE_W-1:0] i_trace_data,
  output logic o_trace_ready,
  output logic o_single_pin_trace_output,
  output logic [TRACE_W-1:0] o_parallel_trace_output,
  output logic o_parallel_trace_valid
);

  localparam int DR_W = (BSR_LEN > `IDCODE_LEN) ? BSR_LEN : `IDCODE_LEN;
  localparam int CNT_W = (TRACE_W > 1) ? $clog2(TRACE_W) : 1;

  // The shift logic and the serial counter cannot serve empty widths.
  // Checked while elaborating, so a bad width never reaches simulation.
  if (BSR_LEN < 1 || TRACE_W < 1) begin : width_check
    $error("BSR_LEN and TRACE_W must be at least 1.");
  end

  // Core clock state.
  jtag_dap_pkg::dps_t dps_reg;
  logic lock_reg, strap_done_reg, jtag_en_reg, trst_en_reg;
  logic swd_acquired_reg, debug_active_reg, reset_req_reg, tog_seen_reg;
  logic tms_out_reg, tms_oe_reg;
  logic [`KEY_CNT_W-1:0] key_cnt_reg;
  logic key_window_open;
  logic [3:0] core_sync;
  logic s_tog, s_lock;
  jtag_dap_pkg::dps_t s_dps;

  // Test clock state.
  jtag_dap_pkg::tap_state_e tap_state_reg;
  jtag_dap_pkg::link_cfg_s link_cfg, s_link;
  logic [BSR_LEN-1:0] s_pins;
  logic [`IR_WIDTH-1:0] ir_reg, ir_shift_reg;
  logic [DR_W-1:0] dr_shift_reg;
  logic [BSR_LEN-1:0] bsr_update_reg;
  logic extest_reg, rst_tog_reg, tdo_reg, tdo_oe_reg, tap_rst;

  // Trace state.
  logic [TRACE_W-1:0] ser_shift_reg, par_data_reg;
  logic [CNT_W-1:0] ser_cnt_reg;
  logic ser_busy_reg, ser_busy_next, ser_out_reg, par_valid_reg, trace_ready_reg;
  logic trace_take;

  // Next TAP state for a sampled mode-select level.
  function automatic jtag_dap_pkg::tap_state_e tap_next(
    input jtag_dap_pkg::tap_state_e s, input logic tms);
    case (s)
      jtag_dap_pkg::st_reset: tap_next = tms ? jtag_dap_pkg::st_reset : jtag_dap_pkg::st_idle;
      jtag_dap_pkg::st_idle: tap_next = tms ? jtag_dap_pkg::st_sel_dr : jtag_dap_pkg::st_idle;
      jtag_dap_pkg::st_sel_dr: tap_next = tms ? jtag_dap_pkg::st_sel_ir : jtag_dap_pkg::st_cap_dr;
      jtag_dap_pkg::st_cap_dr, jtag_dap_pkg::st_shift_dr: begin
        tap_next = tms ? jtag_dap_pkg::st_exit1_dr : jtag_dap_pkg::st_shift_dr;
      end
      jtag_dap_pkg::st_exit1_dr: tap_next = tms ? jtag_dap_pkg::st_upd_dr : jtag_dap_pkg::st_pause_dr;
      jtag_dap_pkg::st_pause_dr: tap_next = tms ? jtag_dap_pkg::st_exit2_dr : jtag_dap_pkg::st_pause_dr;
      jtag_dap_pkg::st_exit2_dr: tap_next = tms ? jtag_dap_pkg::st_upd_dr : jtag_dap_pkg::st_shift_dr;
      jtag_dap_pkg::st_sel_ir: tap_next = tms ? jtag_dap_pkg::st_reset : jtag_dap_pkg::st_cap_ir;
      jtag_dap_pkg::st_cap_ir, jtag_dap_pkg::st_shift_ir: begin
        tap_next = tms ? jtag_dap_pkg::st_exit1_ir : jtag_dap_pkg::st_shift_ir;
      end
      jtag_dap_pkg::st_exit1_ir: tap_next = tms ? jtag_dap_pkg::st_upd_ir : jtag_dap_pkg::st_pause_ir;
      jtag_dap_pkg::st_pause_ir: tap_next = tms ? jtag_dap_pkg::st_exit2_ir : jtag_dap_pkg::st_pause_ir;
      jtag_dap_pkg::st_exit2_ir: tap_next = tms ? jtag_dap_pkg::st_upd_ir : jtag_dap_pkg::st_shift_ir;
      jtag_dap_pkg::st_upd_dr, jtag_dap_pkg::st_upd_ir: begin
        tap_next = tms ? jtag_dap_pkg::st_sel_dr : jtag_dap_pkg::st_idle;
      end
      default: tap_next = jtag_dap_pkg::st_reset;
    endcase
  endfunction

  // Straps come from pins and the reset toggle from the test clock domain.
  jtag_dap_sync #(.W(4)) core_sync_u (
    .i_clk(i_core_clk),
    .i_d({i_debug_port_select_setting, i_nonvolatile_config_latch_lock, rst_tog_reg}),
    .o_q(core_sync)
  );
  assign s_dps = core_sync[3:2];
  assign s_lock = core_sync[1];
  assign s_tog = core_sync[0];

  // Straps are caught once, in the first cycle after reset release. Lockout
  // reads as set until then so nothing opens before the latch is known.
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      strap_done_reg <= 1'b0;
      lock_reg <= 1'b1;
      dps_reg <= `DPS_DISABLED;
      trst_en_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      lock_reg <= s_lock;
      dps_reg <= s_dps;
      trst_en_reg <= (s_dps == `DPS_JTAG5);
    end
  end

  // The TAP is live in either JTAG setting, or after a switch from two-wire.
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      jtag_en_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      jtag_en_reg <= !s_lock && (s_dps == `DPS_JTAG4 || s_dps == `DPS_JTAG5);
    end else if (lock_reg) begin
      jtag_en_reg <= 1'b0;
    end else if (i_swd_switch_to_jtag && swd_acquired_reg && dps_reg != `DPS_DISABLED) begin
      jtag_en_reg <= 1'b1;
    end
  end

  // Key window count; it saturates so the window never reopens.
  assign key_window_open = strap_done_reg && (key_cnt_reg < `KEY_CNT_W'(`KEY_WINDOW_CYC));
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      key_cnt_reg <= '0;
      swd_acquired_reg <= 1'b0;
    end else begin
      if (key_window_open) begin
        key_cnt_reg <= key_cnt_reg + `KEY_CNT_W'(1);
      end
      if (lock_reg && strap_done_reg) begin
        swd_acquired_reg <= 1'b0;
      end else if (key_window_open && i_swd_key_seen) begin
        swd_acquired_reg <= 1'b1;
      end
    end
  end

  // Mode-select is driven only by the two-wire engine before the switch.
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      tms_oe_reg <= 1'b0;
      tms_out_reg <= 1'b0;
    end else begin
      tms_oe_reg <= swd_acquired_reg && !jtag_en_reg && !lock_reg && i_swd_drive;
      tms_out_reg <= i_swd_data;
    end
  end

  // Debug modules stay off until firmware turns them on; only reset or lockout clears.
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      debug_active_reg <= 1'b0;
    end else if (lock_reg && strap_done_reg) begin
      debug_active_reg <= 1'b0;
    end else if (i_fw_debug_enable && strap_done_reg) begin
      debug_active_reg <= 1'b1;
    end
  end

  // Reset requests arrive as a toggle; the seen copy is reloaded in reset so
  // a toggle left over from before cannot fire a spurious request.
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      tog_seen_reg <= s_tog;
      reset_req_reg <= 1'b0;
    end else begin
      tog_seen_reg <= s_tog;
      reset_req_reg <= (s_tog != tog_seen_reg) && strap_done_reg && !lock_reg
                       && (dps_reg != `DPS_DISABLED);
    end
  end

  // Trace beats are taken only while the debug modules are active.
  assign trace_take = i_trace_valid && trace_ready_reg;
  always_comb begin
    ser_busy_next = ser_busy_reg;
    if (trace_take && i_trace_mode == `TRACE_MODE_SERIAL) begin
      ser_busy_next = 1'b1;
    end else if (ser_busy_reg && ser_cnt_reg == CNT_W'(TRACE_W - 1)) begin
      ser_busy_next = 1'b0;
    end
  end

  // Serial trace sends each beat least significant bit first, one per cycle.
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      ser_shift_reg <= '0;
      ser_cnt_reg <= '0;
      ser_busy_reg <= 1'b0;
      ser_out_reg <= 1'b0;
      par_data_reg <= '0;
      par_valid_reg <= 1'b0;
      trace_ready_reg <= 1'b0;
    end else begin
      ser_busy_reg <= ser_busy_next;
      trace_ready_reg <= debug_active_reg && !ser_busy_next;
      par_valid_reg <= trace_take && i_trace_mode == `TRACE_MODE_PARALLEL;
      if (trace_take && i_trace_mode == `TRACE_MODE_PARALLEL) begin
        par_data_reg <= i_trace_data;
      end
      if (trace_take && i_trace_mode == `TRACE_MODE_SERIAL) begin
        ser_shift_reg <= i_trace_data;
        ser_cnt_reg <= '0;
      end else if (ser_busy_reg) begin
        ser_out_reg <= ser_shift_reg[0];
        ser_shift_reg <= ser_shift_reg >> 1;
        ser_cnt_reg <= ser_cnt_reg + CNT_W'(1);
      end else begin
        ser_out_reg <= 1'b0;
      end
    end
  end

  // Control levels cross into the test clock domain with the pin samples.
  assign link_cfg = '{ext_rst_n: i_reset_n, trst_pin_n: i_test_reset_n,
                      jtag_en: jtag_en_reg, trst_en: trst_en_reg,
                      dbg_active: debug_active_reg};
  jtag_dap_sync #(.W($bits(jtag_dap_pkg::link_cfg_s) + BSR_LEN)) link_sync_u (
    .i_clk(i_test_clk),
    .i_d({link_cfg, i_pin_sample}),
    .o_q({s_link, s_pins})
  );

  // The test reset pin only counts in the five-wire setting.
  assign tap_rst = !s_link.ext_rst_n || !s_link.jtag_en
                   || (s_link.trst_en && !s_link.trst_pin_n);

  // TAP controller; five high mode-select edges reach reset from anywhere.
  always_ff @(posedge i_test_clk) begin
    if (tap_rst) begin
      tap_state_reg <= jtag_dap_pkg::st_reset;
    end else begin
      tap_state_reg <= tap_next(tap_state_reg, i_tms);
    end
  end

  // Instruction register; reset selects the identification code.
  always_ff @(posedge i_test_clk) begin
    if (tap_rst || tap_state_reg == jtag_dap_pkg::st_reset) begin
      ir_reg <= `IR_IDCODE;
      ir_shift_reg <= '0;
    end else begin
      case (tap_state_reg)
        jtag_dap_pkg::st_cap_ir: ir_shift_reg <= `IR_CAPTURE;
        jtag_dap_pkg::st_shift_ir: ir_shift_reg <= {i_tdi, ir_shift_reg[`IR_WIDTH-1:1]};
        jtag_dap_pkg::st_upd_ir: ir_reg <= ir_shift_reg;
        default: ir_reg <= ir_reg;
      endcase
    end
  end

  // Data registers share one shifter; the selected length places the input
  // bit, so bypass is one bit long and chains stay short.
  always_ff @(posedge i_test_clk) begin
    if (tap_rst) begin
      dr_shift_reg <= '0;
    end else if (tap_state_reg == jtag_dap_pkg::st_cap_dr) begin
      case (ir_reg)
        `IR_IDCODE: dr_shift_reg <= DR_W'(IDCODE_VALUE);
        `IR_EXTEST, `IR_SAMPLE: dr_shift_reg <= DR_W'(s_pins);
        `IR_DBG_STATUS: dr_shift_reg <= DR_W'(s_link.dbg_active);
        default: dr_shift_reg <= '0;
      endcase
    end else if (tap_state_reg == jtag_dap_pkg::st_shift_dr) begin
      dr_shift_reg <= dr_shift_reg >> 1;
      case (ir_reg)
        `IR_IDCODE: dr_shift_reg[`IDCODE_LEN-1] <= i_tdi;
        `IR_EXTEST, `IR_SAMPLE: dr_shift_reg[BSR_LEN-1] <= i_tdi;
        default: dr_shift_reg[`ONE_BIT_LEN-1] <= i_tdi;
      endcase
    end
  end

  // Update stage drives the pins under EXTEST and raises reset requests.
  always_ff @(posedge i_test_clk) begin
    if (tap_rst) begin
      bsr_update_reg <= '0;
      extest_reg <= 1'b0;
      rst_tog_reg <= 1'b0;
    end else begin
      extest_reg <= (ir_reg == `IR_EXTEST) && tap_state_reg != jtag_dap_pkg::st_reset;
      if (tap_state_reg == jtag_dap_pkg::st_upd_dr) begin
        if (ir_reg == `IR_EXTEST || ir_reg == `IR_SAMPLE) begin
          bsr_update_reg <= dr_shift_reg[BSR_LEN-1:0];
        end
        if (ir_reg == `IR_RESET_REQ && dr_shift_reg[0]) begin
          rst_tog_reg <= !rst_tog_reg;
        end
      end
    end
  end

  // Serial output changes on the falling edge so the host samples it clean.
  always_ff @(negedge i_test_clk) begin
    if (tap_rst) begin
      tdo_reg <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else begin
      tdo_reg <= (tap_state_reg == jtag_dap_pkg::st_shift_ir) ? ir_shift_reg[0]
                                                              : dr_shift_reg[0];
      tdo_oe_reg <= (tap_state_reg == jtag_dap_pkg::st_shift_ir)
                    || (tap_state_reg == jtag_dap_pkg::st_shift_dr);
    end
  end

  // Outputs are flip-flops named above.
  assign o_tdo = tdo_reg;
  assign o_tdo_oe = tdo_oe_reg;
  assign o_tms_out = tms_out_reg;
  assign o_tms_oe = tms_oe_reg;
  assign o_jtag_pins_enabled = jtag_en_reg;
  assign o_swd_acquired = swd_acquired_reg;
  assign o_debug_modules_active = debug_active_reg;
  assign o_device_reset_req = reset_req_reg;
  assign o_pin_drive = bsr_update_reg;
  assign o_pin_extest = extest_reg;
  assign o_trace_ready = trace_ready_reg;
  assign o_single_pin_trace_output = ser_out_reg;
  assign o_parallel_trace_output = par_data_reg;
  assign o_parallel_trace_valid = par_valid_reg;

  tap_reset_a: assert property (@(posedge i_test_clk) disable iff (tap_rst)
    (i_tms)[*5] |=> tap_state_reg == jtag_dap_pkg::st_reset)
    else $error("TAP not in reset after five high mode-select edges.");

  bypass_len_a: assert property (@(posedge i_test_clk) disable iff (tap_rst)
    (ir_reg == `IR_BYPASS && tap_state_reg == jtag_dap_pkg::st_shift_dr)
    |=> dr_shift_reg[0] == $past(i_tdi))
    else $error("Bypass path is not one bit long.");

  trst_pin_a: assert property (@(posedge i_test_clk)
    (s_link.trst_en && !s_link.trst_pin_n) |=> tap_state_reg == jtag_dap_pkg::st_reset)
    else $error("Test reset pin did not reset the TAP.");

  lockout_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (lock_reg && strap_done_reg) |=> !jtag_en_reg && !swd_acquired_reg
    && !debug_active_reg && !reset_req_reg && !tms_oe_reg)
    else $error("An interface is open while locked out.");

  debug_off_a: assert property (@(posedge i_core_clk)
    !i_reset_n |=> !debug_active_reg && !trace_ready_reg ##1 !trace_ready_reg)
    else $error("Debug modules active without firmware enable.");

  debug_on_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (i_fw_debug_enable && strap_done_reg && !lock_reg) |=> debug_active_reg ##1 debug_active_reg)
    else $error("Firmware enable did not activate the debug modules.");

  reset_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    reset_req_reg |-> dps_reg != `DPS_DISABLED && $past(s_tog) != $past(tog_seen_reg))
    else $error("Reset request without a TAP write or while ports disabled.");

  default_jtag_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (!strap_done_reg && !s_lock && s_dps == `DPS_JTAG4) |=> jtag_en_reg ##1 !tms_oe_reg)
    else $error("Default setting did not start four-wire JTAG.");

  tms_input_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    jtag_en_reg |=> !tms_oe_reg)
    else $error("Mode-select driven while in JTAG mode.");

  key_window_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    $rose(swd_acquired_reg) |-> $past(key_cnt_reg) < `KEY_CNT_W'(`KEY_WINDOW_CYC))
    else $error("Two-wire key accepted outside the key window.");

  par_trace_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (trace_take && i_trace_mode == `TRACE_MODE_PARALLEL)
    |=> par_valid_reg && par_data_reg == $past(i_trace_data))
    else $error("Parallel trace beat lost.");

endmodule

`default_nettype wire

// *** test_jtag_debug_access_port.sv ***
/*
  Self-checking bench for the debug access port.
  Assumes the host model in host_probe.sv; straps change only in reset.
*/
`timescale 1ns/1ps
`default_nettype none
module test_jtag_debug_access_port;
  localparam logic [31:0] idc_value = 32'h1234_5678; // Arbitrary value.
  int err_total = 0;
  int num_checks = 0;
  int rr_cnt = 0;
  logic clk, rst_n, tck, tms, tdi, tdo, tms_oe, pins_en, acq, dbg_act, rr;
  logic lock, key, sw_jtag, sw_drive, fw_en, tvalid, tready, pval;
  logic trst_n, tmode, sout, tdo_oe;
  logic [1:0] debug_port_select_setting;
  logic [3:0] tdata, par;
  logic [39:0] got;

  host_probe host (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));
  jtag_debug_access_port #(.IDCODE_VALUE(idc_value)) dut (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_test_clk(tck), .i_tms(tms), .i_tdi(tdi),
    .i_test_reset_n(trst_n), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_tms_out(), .o_tms_oe(tms_oe),
    .i_debug_port_select_setting(debug_port_select_setting), .i_nonvolatile_config_latch_lock(lock),
    .i_swd_key_seen(key), .i_swd_switch_to_jtag(sw_jtag), .i_swd_data(1'b0),
    .i_swd_drive(sw_drive), .i_fw_debug_enable(fw_en), .o_jtag_pins_enabled(pins_en),
    .o_swd_acquired(acq), .o_debug_modules_active(dbg_act), .o_device_reset_req(rr),
    .i_pin_sample(8'h00), .o_pin_drive(), .o_pin_extest(), .i_trace_mode(tmode),
    .i_trace_valid(tvalid), .i_trace_data(tdata), .o_trace_ready(tready),
    .o_single_pin_trace_output(sout), .o_parallel_trace_output(par),
    .o_parallel_trace_valid(pval));

  // Core clock, 40 ns period.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Reset request pulses are counted here since they last one cycle.
  always @(posedge clk) if (rr) rr_cnt++;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Waits whole cycles, then steps past the edge so outputs have settled.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Straps move only while reset is held, which the capture logic relies on.
  // The test clock runs during reset so the TAP side is cleared as well.
  task automatic do_reset(input logic [1:0] s, input logic l);
    @(posedge clk);
    rst_n <= 1'b0;
    debug_port_select_setting <= s;
    lock <= l;
    cyc(3);
    tap(40'hff, 40'h0, 8);
    cyc(11);
    @(posedge clk) rst_n <= 1'b1;
    cyc(3);
  endtask
  // Plays n bits of mode-select and data, LSB first, keeping data out.
  task automatic tap(input logic [39:0] m, input logic [39:0] d, input int n);
    for (int k = 0; k < n; k++) host.bit_cycle(m[k], d[k], got[k]);
  endtask
  task automatic pulse_fw();
    @(posedge clk) fw_en <= 1'b1;
    @(posedge clk) fw_en <= 1'b0;
    cyc(2);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Defaults after reset, firmware enable, and loss of it on reset.
  task automatic t_defaults();
    do_reset(2'h0, 1'b0);
    chk("pins enabled", 1, pins_en);
    chk("mode-select drive", 0, tms_oe);
    chk("debug active", 0, dbg_act);
    pulse_fw();
    chk("debug active", 1, dbg_act);
    do_reset(2'h0, 1'b0);
    chk("debug after reset", 0, dbg_act);
    $display("test defaults done");
  endtask
  // Identity code read after a mode-select only TAP reset.
  task automatic t_idcode();
    tap(40'hff, 40'h0, 8);
    tap(40'h18_0000_0002, 40'h0, 38);
    chk("idcode", idc_value, got[35:4]);
    tap(40'h30_0383, 40'ha_50f0, 23);
    chk("bypass", 8'ha5, got[20:13]);
    $display("test idcode done");
  endtask
  // Reset through the TAP register, then refused with ports disabled.
  task automatic t_rstreq();
    rr_cnt = 0;
    tap(40'h3383, 40'h1080, 15);
    chk("ir capture", 4'h1, got[7:4]);
    cyc(20);
    chk("reset pulses", 1, rr_cnt);
    do_reset(2'h3, 1'b0);
    chk("pins disabled", 0, pins_en);
    tap(40'hff, 40'h0, 8);
    tap(40'h3383, 40'h1080, 15);
    cyc(20);
    chk("refused reset", 1, rr_cnt);
    $display("test reset request done");
  endtask
  // The test reset pin resets the TAP in the five-wire setting.
  task automatic t_trst();
    do_reset(2'h1, 1'b0);
    tap(40'hff, 40'h0, 8);
    tap(40'h2, 40'h0, 5);
    chk("shift before pin reset", 1, tdo_oe);
    @(posedge clk) trst_n <= 1'b0;
    cyc(1);
    tap(40'h0, 40'h0, 4);
    @(posedge clk) trst_n <= 1'b1;
    cyc(1);
    chk("shift after pin reset", 0, tdo_oe);
    $display("test reset pin done");
  endtask
  // Permanent lockout shuts the port and the debug enable.
  task automatic t_lock();
    do_reset(2'h0, 1'b1);
    chk("locked pins", 0, pins_en);
    pulse_fw();
    chk("locked debug", 0, dbg_act);
    $display("test lockout done");
  endtask
  // Two-wire key inside the window, switch to JTAG, then a key outside it.
  task automatic t_key();
    do_reset(2'h2, 1'b0);
    chk("pins before key", 0, pins_en);
    @(posedge clk) key <= 1'b1;
    @(posedge clk) key <= 1'b0;
    sw_drive <= 1'b1;
    cyc(2);
    chk("acquired", 1, acq);
    chk("mode-select driven", 1, tms_oe);
    @(posedge clk) sw_jtag <= 1'b1;
    @(posedge clk) sw_jtag <= 1'b0;
    cyc(2);
    chk("pins after switch", 1, pins_en);
    chk("mode-select input only", 0, tms_oe);
    @(posedge clk) sw_drive <= 1'b0;
    do_reset(2'h2, 1'b0);
    cyc(205);
    @(posedge clk) key <= 1'b1;
    @(posedge clk) key <= 1'b0;
    cyc(2);
    chk("late key", 0, acq);
    $display("test key window done");
  endtask
  // A parallel beat appears once with its data; a serial beat goes LSB first.
  task automatic t_trace();
    logic [3:0] beat;
    beat = 4'hb;
    do_reset(2'h0, 1'b0);
    pulse_fw();
    chk("trace ready", 1, tready);
    @(posedge clk) tvalid <= 1'b1;
    tdata <= 4'ha;
    @(posedge clk) tvalid <= 1'b0;
    #1;
    chk("trace valid", 1, pval);
    chk("trace data", 4'ha, par);
    cyc(1);
    chk("trace valid once", 0, pval);
    @(posedge clk) tmode <= 1'b0;
    tvalid <= 1'b1;
    tdata <= beat;
    @(posedge clk) tvalid <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      cyc(1);
      chk("serial bit", 32'(beat[k]), 32'(sout));
      if (k == 0) chk("ready while serial", 0, tready);
    end
    $display("test trace done");
  endtask

  // Main sequence.
  initial begin
    {rst_n, lock, key, sw_jtag, sw_drive, fw_en, tvalid} = 7'h00;
    debug_port_select_setting = 2'h0;
    tdata = 4'h0;
    trst_n = 1'b1;
    tmode = 1'b1;
    t_defaults();
    t_idcode();
    t_rstreq();
    t_trst();
    t_lock();
    t_key();
    t_trace();
    finish_test();
  end
  // Watchdog: the tests need about 20 us.
  initial begin
    #100000;
    err_total++;
    finish_test();
  end
endmodule
`default_nettype wire
